// *** logic/eampm_pkg.sv ***
package eampm_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] BUS_SELECT_REGISTER_IDX     = 16'h1c00;
    localparam logic [15:0] PIN_LEVEL_STATUS_IDX        = 16'h1c01;
    localparam logic [15:0] UPPER_ADDR_PULL_INHIBIT_IDX = 16'h1c18;
    localparam logic [15:0] MID_ADDR_PULL_INHIBIT_IDX   = 16'h1c4d;

    localparam logic [15:0] BUS_SELECT_REGISTER_ADDR     = 16'(BUS_SELECT_REGISTER_IDX << 2);
    localparam logic [15:0] PIN_LEVEL_STATUS_ADDR        = 16'(PIN_LEVEL_STATUS_IDX << 2);
    localparam logic [15:0] UPPER_ADDR_PULL_INHIBIT_ADDR = 16'(UPPER_ADDR_PULL_INHIBIT_IDX << 2);
    localparam logic [15:0] MID_ADDR_PULL_INHIBIT_ADDR   = 16'(MID_ADDR_PULL_INHIBIT_IDX << 2);

    // Widths
    localparam int APB_ADDR_W   = 16;
    localparam int APB_DATA_W   = 32;
    localparam int REG_W        = 16;
    localparam int SHARED_PINS  = 4;
    localparam int DEDICATED_PINS = 8;
    localparam int FIRST_DEDICATED_BIT = 7;
    localparam int LAST_SHARED_BIT     = 18;

    // Bus select register fields, one select bit per shared pin (1 = address)
    localparam int ADDR_BIT15_SELECT_POS = 0;
    localparam int ADDR_BIT16_SELECT_POS = 1;
    localparam int ADDR_BIT17_SELECT_POS = 2;
    localparam int ADDR_BIT18_SELECT_POS = 3;

    // Pull inhibit fields (1 = pull-down off); status field positions
    localparam int UPPER_PULL_LSB   = 0;
    localparam int MID_PULL_LSB     = 0;
    localparam int STATUS_SHARED_LSB    = 0;
    localparam int STATUS_DEDICATED_LSB = 8;

    // Dedicated pin slots that double as NAND latch strobes
    localparam int ALE_SLOT = 11 - FIRST_DEDICATED_BIT;
    localparam int CLE_SLOT = 12 - FIRST_DEDICATED_BIT;

    // Reset values
    localparam logic [SHARED_PINS-1:0]    BUS_SELECT_RESET  = 4'h0;
    localparam logic [SHARED_PINS-1:0]    UPPER_PULL_RESET  = 4'hf;
    localparam logic [DEDICATED_PINS-1:0] MID_PULL_RESET    = 8'hff;

    // Bus answer state, one-hot
    typedef enum logic [1:0] {
        APB_IDLE = 2'b01,
        APB_RESP = 2'b10
    } eampm_apb_state_e;

endpackage

// *** logic/eampm_pin_if.sv ***
`timescale 1ns/1ps
interface eampm_pin_if;
    import eampm_pkg::*;

    logic [SHARED_PINS-1:0] addr_select;
    logic [SHARED_PINS-1:0] line_out;
    logic [SHARED_PINS-1:0] line_oe;
    logic [SHARED_PINS-1:0] mem_addr;
    logic                   mem_oe;
    logic [SHARED_PINS-1:0] pin_out;
    logic [SHARED_PINS-1:0] pin_oe;

    // Control side feeds selections and both sources
    modport ctrl (
        output addr_select,
        output line_out,
        output line_oe,
        output mem_addr,
        output mem_oe,
        input  pin_out,
        input  pin_oe
    );

    // Mux side drives the pad
    modport mux (
        input  addr_select,
        input  line_out,
        input  line_oe,
        input  mem_addr,
        input  mem_oe,
        output pin_out,
        output pin_oe
    );
endinterface

// *** logic/eampm_shared_pin.sv ***
`timescale 1ns/1ps
module eampm_shared_pin (
    input wire logic clk_in,
    input wire logic rst_n_in,
    eampm_pin_if.mux pins
);
    import eampm_pkg::*;

    logic [SHARED_PINS-1:0] next_pin_out;
    logic [SHARED_PINS-1:0] next_pin_oe;

    // One mux cell per shared pin
    genvar g;
    generate
        for (g = 0; g < SHARED_PINS; g++) begin : g_pin
            always_comb begin
                if (pins.addr_select[g]) begin
                    next_pin_out[g] = pins.mem_addr[g];
                    next_pin_oe[g]  = pins.mem_oe;
                end else begin
                    next_pin_out[g] = pins.line_out[g];
                    next_pin_oe[g]  = pins.line_oe[g];
                end
            end
        end
    endgenerate

    // Pad drive registered in one process so the top outputs come from flops
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pins.pin_out <= '0;
            pins.pin_oe  <= '0;
        end else begin
            pins.pin_out <= next_pin_out;
            pins.pin_oe  <= next_pin_oe;
        end
    end
endmodule

// *** logic/eampm_top.sv ***
// Function
// - A select bit per shared pin picks its general-purpose line or address bit 15 to 18.
// - After reset every shared pin is a general-purpose line until its select bit is set.
// - The upper pull inhibit register switches the pull-down of each shared address pin.
// - The mid pull inhibit register sets the pull-down of dedicated address pins 7 to 14.
// - All these pull-downs are off after reset until software enables them.
// - With NAND flash, address pin 12 carries the command latch strobe.
// - With NAND flash, address pin 11 carries the address latch strobe.
// - Address pins 7 to 14 belong to the memory port alone, with no general-purpose use.
`timescale 1ns/1ps
module eampm_top (
    input  wire logic                                  CLOCK_IN,
    input  wire logic                                  ARST_N_IN,
    input  wire logic                                  PSEL_IN,
    input  wire logic                                  PENABLE_IN,
    input  wire logic                                  PWRITE_IN,
    input  wire logic [eampm_pkg::APB_ADDR_W-1:0]      PADDR_IN,
    input  wire logic [eampm_pkg::APB_DATA_W-1:0]      PWDATA_IN,
    output logic      [eampm_pkg::APB_DATA_W-1:0]      PRDATA_OUT,
    output logic                                       PREADY_OUT,
    output logic                                       PSLVERR_OUT,
    input  wire logic [eampm_pkg::LAST_SHARED_BIT:
                       eampm_pkg::FIRST_DEDICATED_BIT]     EXT_ADDRESS_LINE_IN,
    input  wire logic                                  EXT_ADDRESS_OE_IN,
    input  wire logic                                  EXT_MEM_PORT_NAND_IN,
    input  wire logic                                  EXT_MEM_PORT_CLE_IN,
    input  wire logic                                  EXT_MEM_PORT_ALE_IN,
    input  wire logic [eampm_pkg::SHARED_PINS-1:0]     GENERAL_PURPOSE_LINE_DRIVE_IN,
    input  wire logic [eampm_pkg::SHARED_PINS-1:0]     GENERAL_PURPOSE_LINE_OE_IN,
    output logic      [eampm_pkg::SHARED_PINS-1:0]     GENERAL_PURPOSE_LINE_LEVEL_OUT,
    input  wire logic [eampm_pkg::SHARED_PINS-1:0]     SHARED_PIN_IN,
    output logic      [eampm_pkg::SHARED_PINS-1:0]     SHARED_PIN_OUT,
    output logic      [eampm_pkg::SHARED_PINS-1:0]     SHARED_PIN_OE_OUT,
    input  wire logic [eampm_pkg::DEDICATED_PINS-1:0]  DEDICATED_PIN_IN,
    output logic      [eampm_pkg::DEDICATED_PINS-1:0]  DEDICATED_PIN_OUT,
    output logic      [eampm_pkg::DEDICATED_PINS-1:0]  DEDICATED_PIN_OE_OUT,
    output logic      [eampm_pkg::SHARED_PINS-1:0]     UPPER_INTERNAL_PULLDOWN_EN_OUT,
    output logic      [eampm_pkg::DEDICATED_PINS-1:0]  MID_INTERNAL_PULLDOWN_EN_OUT
);
    import eampm_pkg::*;

    // Reset release synchroniser
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Pad level synchronisers; first stage is read only by the second
    logic [SHARED_PINS-1:0]    shared_meta;
    logic [SHARED_PINS-1:0]    shared_level;
    logic [DEDICATED_PINS-1:0] ded_meta;
    logic [DEDICATED_PINS-1:0] ded_level;

    always_ff @(posedge CLOCK_IN or negedge rst_n) begin
        if (!rst_n) begin
            shared_meta  <= '0;
            shared_level <= '0;
            ded_meta     <= '0;
            ded_level    <= '0;
        end else begin
            shared_meta  <= SHARED_PIN_IN;
            shared_level <= shared_meta;
            ded_meta     <= DEDICATED_PIN_IN;
            ded_level    <= ded_meta;
        end
    end

    // Register file and bus answer state
    eampm_apb_state_e          apb_state;
    eampm_apb_state_e          next_apb_state;
    logic [SHARED_PINS-1:0]    bus_select_register;
    logic [SHARED_PINS-1:0]    next_bus_select_register;
    logic [SHARED_PINS-1:0]    upper_addr_pull_inhibit;
    logic [SHARED_PINS-1:0]    next_upper_addr_pull_inhibit;
    logic [DEDICATED_PINS-1:0] mid_addr_pull_inhibit;
    logic [DEDICATED_PINS-1:0] next_mid_addr_pull_inhibit;
    logic [APB_DATA_W-1:0]     prdata;
    logic [APB_DATA_W-1:0]     next_prdata;
    logic                      pready;
    logic                      next_pready;
    logic                      pslverr;
    logic                      next_pslverr;
    logic [REG_W-1:0]          read_word;
    logic                      addr_hit;
    logic                      write_now;

    // Read mux; unimplemented bits read as zero
    always_comb begin
        read_word = '0;
        addr_hit  = 1'b1;
        case (PADDR_IN)
            BUS_SELECT_REGISTER_ADDR: begin
                read_word[SHARED_PINS-1:0] = bus_select_register;
            end
            PIN_LEVEL_STATUS_ADDR: begin
                read_word[STATUS_SHARED_LSB +: SHARED_PINS]      = shared_level;
                read_word[STATUS_DEDICATED_LSB +: DEDICATED_PINS] = ded_level;
            end
            UPPER_ADDR_PULL_INHIBIT_ADDR: begin
                read_word[UPPER_PULL_LSB +: SHARED_PINS] = upper_addr_pull_inhibit;
            end
            MID_ADDR_PULL_INHIBIT_ADDR: begin
                read_word[MID_PULL_LSB +: DEDICATED_PINS] = mid_addr_pull_inhibit;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // Writes land only on the edge where the master sees ready
    assign write_now = (apb_state == APB_RESP) & PSEL_IN & PENABLE_IN & PWRITE_IN & addr_hit;

    // Bus answer: one wait cycle, then ready for exactly one cycle
    always_comb begin
        next_apb_state               = apb_state;
        next_pready                  = 1'b0;
        next_prdata                  = prdata;
        next_pslverr                 = 1'b0;
        next_bus_select_register     = bus_select_register;
        next_upper_addr_pull_inhibit = upper_addr_pull_inhibit;
        next_mid_addr_pull_inhibit   = mid_addr_pull_inhibit;
        case (apb_state)
            APB_IDLE: begin
                if (PSEL_IN && PENABLE_IN) begin
                    next_apb_state = APB_RESP;
                    next_pready    = 1'b1;
                    next_pslverr   = ~addr_hit;
                    next_prdata    = PWRITE_IN ? '0 : {{(APB_DATA_W-REG_W){1'b0}}, read_word};
                end
            end
            APB_RESP: begin
                next_apb_state = APB_IDLE;
                if (write_now) begin
                    case (PADDR_IN)
                        BUS_SELECT_REGISTER_ADDR: begin
                            next_bus_select_register[ADDR_BIT15_SELECT_POS] =
                                PWDATA_IN[ADDR_BIT15_SELECT_POS];
                            next_bus_select_register[ADDR_BIT16_SELECT_POS] =
                                PWDATA_IN[ADDR_BIT16_SELECT_POS];
                            next_bus_select_register[ADDR_BIT17_SELECT_POS] =
                                PWDATA_IN[ADDR_BIT17_SELECT_POS];
                            next_bus_select_register[ADDR_BIT18_SELECT_POS] =
                                PWDATA_IN[ADDR_BIT18_SELECT_POS];
                        end
                        UPPER_ADDR_PULL_INHIBIT_ADDR: begin
                            next_upper_addr_pull_inhibit =
                                PWDATA_IN[UPPER_PULL_LSB +: SHARED_PINS];
                        end
                        MID_ADDR_PULL_INHIBIT_ADDR: begin
                            next_mid_addr_pull_inhibit =
                                PWDATA_IN[MID_PULL_LSB +: DEDICATED_PINS];
                        end
                        default: begin
                            // Status is read-only; writes are dropped
                            next_apb_state = APB_IDLE;
                        end
                    endcase
                end
            end
            default: begin
                next_apb_state = APB_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK_IN or negedge rst_n) begin
        if (!rst_n) begin
            apb_state               <= APB_IDLE;
            pready                  <= 1'b0;
            prdata                  <= '0;
            pslverr                 <= 1'b0;
            bus_select_register     <= BUS_SELECT_RESET;
            upper_addr_pull_inhibit <= UPPER_PULL_RESET;
            mid_addr_pull_inhibit   <= MID_PULL_RESET;
        end else begin
            apb_state               <= next_apb_state;
            pready                  <= next_pready;
            prdata                  <= next_prdata;
            pslverr                 <= next_pslverr;
            bus_select_register     <= next_bus_select_register;
            upper_addr_pull_inhibit <= next_upper_addr_pull_inhibit;
            mid_addr_pull_inhibit   <= next_mid_addr_pull_inhibit;
        end
    end

    // Pad-facing outputs: pulls and dedicated pins
    logic [SHARED_PINS-1:0]    upper_pd_en;
    logic [SHARED_PINS-1:0]    next_upper_pd_en;
    logic [DEDICATED_PINS-1:0] mid_pd_en;
    logic [DEDICATED_PINS-1:0] next_mid_pd_en;
    logic [DEDICATED_PINS-1:0] ded_out;
    logic [DEDICATED_PINS-1:0] next_ded_out;
    logic [DEDICATED_PINS-1:0] ded_oe;
    logic [DEDICATED_PINS-1:0] next_ded_oe;

    always_comb begin
        // Inhibit bit set means pull-down off
        next_upper_pd_en = ~upper_addr_pull_inhibit;
        next_mid_pd_en   = ~mid_addr_pull_inhibit;
        next_ded_out = EXT_ADDRESS_LINE_IN[FIRST_DEDICATED_BIT +: DEDICATED_PINS];
        next_ded_oe  = {DEDICATED_PINS{EXT_ADDRESS_OE_IN}};
        if (EXT_MEM_PORT_NAND_IN) begin
            next_ded_out[CLE_SLOT] = EXT_MEM_PORT_CLE_IN;
            next_ded_out[ALE_SLOT] = EXT_MEM_PORT_ALE_IN;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge rst_n) begin
        if (!rst_n) begin
            upper_pd_en <= '0;
            mid_pd_en   <= '0;
            ded_out     <= '0;
            ded_oe      <= '0;
        end else begin
            upper_pd_en <= next_upper_pd_en;
            mid_pd_en   <= next_mid_pd_en;
            ded_out     <= next_ded_out;
            ded_oe      <= next_ded_oe;
        end
    end

    // Shared pin muxes
    eampm_pin_if pin_bus ();

    assign pin_bus.addr_select = bus_select_register;
    assign pin_bus.line_out    = GENERAL_PURPOSE_LINE_DRIVE_IN;
    assign pin_bus.line_oe     = GENERAL_PURPOSE_LINE_OE_IN;
    assign pin_bus.mem_addr    = EXT_ADDRESS_LINE_IN[LAST_SHARED_BIT -: SHARED_PINS];
    assign pin_bus.mem_oe      = EXT_ADDRESS_OE_IN;

    eampm_shared_pin u_shared_pin (
        .clk_in   (CLOCK_IN),
        .rst_n_in (rst_n),
        .pins     (pin_bus.mux)
    );

    // Outputs, each straight from a flop
    assign PRDATA_OUT                     = prdata;
    assign PREADY_OUT                     = pready;
    assign PSLVERR_OUT                    = pslverr;
    assign SHARED_PIN_OUT                 = pin_bus.pin_out;
    assign SHARED_PIN_OE_OUT              = pin_bus.pin_oe;
    assign GENERAL_PURPOSE_LINE_LEVEL_OUT = shared_level;
    assign DEDICATED_PIN_OUT              = ded_out;
    assign DEDICATED_PIN_OE_OUT           = ded_oe;
    assign UPPER_INTERNAL_PULLDOWN_EN_OUT = upper_pd_en;
    assign MID_INTERNAL_PULLDOWN_EN_OUT   = mid_pd_en;

    // Helper: set once any pull inhibit register has been written
    logic pull_written;
    always_ff @(posedge CLOCK_IN or negedge rst_n) begin
        if (!rst_n) begin
            pull_written <= 1'b0;
        end else if (write_now && (PADDR_IN == UPPER_ADDR_PULL_INHIBIT_ADDR ||
                                   PADDR_IN == MID_ADDR_PULL_INHIBIT_ADDR)) begin
            pull_written <= 1'b1;
        end
    end

    property p_addr_route;
        @(posedge CLOCK_IN) disable iff (!rst_n)
        bus_select_register[ADDR_BIT17_SELECT_POS] |=>
            SHARED_PIN_OUT[ADDR_BIT17_SELECT_POS] == $past(EXT_ADDRESS_LINE_IN[17]);
    endproperty
    a_addr_route: assert property (p_addr_route)
        else $error("Shared pin 17 did not follow address in address mode");

    property p_reset_line_role;
        @(posedge CLOCK_IN) disable iff (!rst_n)
        $rose(rst_n) |-> (bus_select_register == 4'h0) ##1 (SHARED_PIN_OE_OUT ==
            $past(GENERAL_PURPOSE_LINE_OE_IN));
    endproperty
    a_reset_line_role: assert property (p_reset_line_role)
        else $error("Shared pins not in line role after reset");

    property p_upper_pull;
        @(posedge CLOCK_IN) disable iff (!rst_n)
        (write_now && PADDR_IN == UPPER_ADDR_PULL_INHIBIT_ADDR) |->
            ##2 UPPER_INTERNAL_PULLDOWN_EN_OUT == ~$past(PWDATA_IN[3:0], 2);
    endproperty
    a_upper_pull: assert property (p_upper_pull)
        else $error("Upper pull-down enable does not match written inhibit");

    property p_mid_pull;
        @(posedge CLOCK_IN) disable iff (!rst_n)
        (write_now && PADDR_IN == MID_ADDR_PULL_INHIBIT_ADDR) ##2 1'b1 |->
            MID_INTERNAL_PULLDOWN_EN_OUT == ~$past(PWDATA_IN[7:0], 2);
    endproperty
    a_mid_pull: assert property (p_mid_pull)
        else $error("Mid pull-down enable does not match written inhibit");

    property p_pulls_off;
        @(posedge CLOCK_IN) disable iff (!rst_n)
        !pull_written |-> (UPPER_INTERNAL_PULLDOWN_EN_OUT == 4'h0) &&
            (MID_INTERNAL_PULLDOWN_EN_OUT == 8'h00);
    endproperty
    a_pulls_off: assert property (p_pulls_off)
        else $error("Pull-down enabled before software wrote an inhibit register");

    property p_cle_strobe;
        @(posedge CLOCK_IN) disable iff (!rst_n)
        (EXT_MEM_PORT_NAND_IN && EXT_MEM_PORT_CLE_IN) |=> DEDICATED_PIN_OUT[5];
    endproperty
    a_cle_strobe: assert property (p_cle_strobe)
        else $error("Address pin 12 did not carry the command latch strobe");

    property p_ale_strobe;
        @(posedge CLOCK_IN) disable iff (!rst_n)
        EXT_MEM_PORT_NAND_IN |=> DEDICATED_PIN_OUT[4] == $past(EXT_MEM_PORT_ALE_IN);
    endproperty
    a_ale_strobe: assert property (p_ale_strobe)
        else $error("Address pin 11 did not carry the address latch strobe");

    property p_dedicated_only;
        @(posedge CLOCK_IN) disable iff (!rst_n)
        !EXT_ADDRESS_OE_IN ##1 !EXT_ADDRESS_OE_IN |-> DEDICATED_PIN_OE_OUT == 8'h00;
    endproperty
    a_dedicated_only: assert property (p_dedicated_only)
        else $error("Dedicated address pin driven without the memory port");

    property p_line_owns_pin;
        @(posedge CLOCK_IN) disable iff (!rst_n)
        (!bus_select_register[0] && !GENERAL_PURPOSE_LINE_OE_IN[0]) |=> !SHARED_PIN_OE_OUT[0];
    endproperty
    a_line_owns_pin: assert property (p_line_owns_pin)
        else $error("Memory port drove shared pin 15 in line mode");

endmodule

// *** dv/eampm_pad_model.sv ***
`timescale 1ns/1ps
module eampm_pad_model
    import eampm_pkg::*;
(
    input  wire logic                      clk_in,
    input  wire logic [SHARED_PINS-1:0]    sh_out_in,
    input  wire logic [SHARED_PINS-1:0]    sh_oe_in,
    input  wire logic [SHARED_PINS-1:0]    sh_pd_in,
    input  wire logic [DEDICATED_PINS-1:0] dd_out_in,
    input  wire logic [DEDICATED_PINS-1:0] dd_oe_in,
    input  wire logic [DEDICATED_PINS-1:0] dd_pd_in,
    output logic      [SHARED_PINS-1:0]    sh_pad_out,
    output logic      [DEDICATED_PINS-1:0] dd_pad_out
);
    logic [SHARED_PINS-1:0]    sh_last = '0;
    logic [DEDICATED_PINS-1:0] dd_last = '0;
    // Memory never drives address pads; a floating pad with its pull-down off toggles so stale levels are caught
    assign sh_pad_out = (sh_oe_in & sh_out_in) | (~sh_oe_in & ~sh_pd_in & ~sh_last);
    assign dd_pad_out = (dd_oe_in & dd_out_in) | (~dd_oe_in & ~dd_pd_in & ~dd_last);
    // Remember last pad level
    always_ff @(posedge clk_in) begin
        sh_last <= sh_pad_out;
        dd_last <= dd_pad_out;
    end
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
    import eampm_pkg::*;
    logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed, wd;
    logic [15:0] ev, em;
    logic [18:7] ext_addr;
    logic        ext_oe, nand_en, cle, ale;
    logic [3:0]  gp_drv, gp_oe, gp_lvl, sh_pad, sh_out, sh_oe, up_pd, es, eo;
    logic [7:0]  dd_pad, dd_out, dd_oe, mid_pd, ed;
    int          error_cnt, checks, sel_m, up_m, mid_m;
    eampm_top dut (.CLOCK_IN(clk), .ARST_N_IN(arst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .EXT_ADDRESS_LINE_IN(ext_addr),
        .EXT_ADDRESS_OE_IN(ext_oe), .EXT_MEM_PORT_NAND_IN(nand_en), .EXT_MEM_PORT_CLE_IN(cle),
        .EXT_MEM_PORT_ALE_IN(ale), .GENERAL_PURPOSE_LINE_DRIVE_IN(gp_drv),
        .GENERAL_PURPOSE_LINE_OE_IN(gp_oe), .GENERAL_PURPOSE_LINE_LEVEL_OUT(gp_lvl),
        .SHARED_PIN_IN(sh_pad), .SHARED_PIN_OUT(sh_out), .SHARED_PIN_OE_OUT(sh_oe),
        .DEDICATED_PIN_IN(dd_pad), .DEDICATED_PIN_OUT(dd_out), .DEDICATED_PIN_OE_OUT(dd_oe),
        .UPPER_INTERNAL_PULLDOWN_EN_OUT(up_pd), .MID_INTERNAL_PULLDOWN_EN_OUT(mid_pd));
    eampm_pad_model pads (.clk_in(clk), .sh_out_in(sh_out), .sh_oe_in(sh_oe), .sh_pd_in(up_pd),
        .dd_out_in(dd_out), .dd_oe_in(dd_oe), .dd_pd_in(mid_pd), .sh_pad_out(sh_pad),
        .dd_pad_out(dd_pad));
    // Free-running 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic test_done();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        checks++;
        if ((got & m) !== (exp & m)) begin
            error_cnt++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Master waits on pready, never on a fixed count
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Reset held four cycles, then model registers return to reset values
    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk({up_pd, mid_pd, sh_oe}, 16'h0, 16'hffff);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        sel_m = 0;
        up_m = 'hf;
        mid_m = 'hff;
    endtask
    // Expected pads from the model registers
    task automatic pin_checks();
        for (int i = 0; i < 4; i++) begin
            es[i] = sel_m[i] ? ext_addr[15+i] : gp_drv[i];
            eo[i] = sel_m[i] ? ext_oe : gp_oe[i];
        end
        ed = ext_addr[14:7];
        if (nand_en) begin
            ed[5] = cle;
            ed[4] = ale;
        end
        chk({sh_out, sh_oe}, {es, eo}, 32'hff);
        chk({dd_out, dd_oe}, {ed, {8{ext_oe}}}, 32'hffff);
        chk({up_pd, mid_pd}, {~up_m[3:0], ~mid_m[7:0]}, 32'hfff);
        chk(gp_lvl, es & eo, eo | ~up_m[3:0]);
        apb(1'b0, PIN_LEVEL_STATUS_ADDR, 32'h0);
        ev = {ed & {8{ext_oe}}, 4'h0, es & eo};
        em = {{8{ext_oe}} | ~mid_m[7:0], 4'h0, eo | ~up_m[3:0]};
        chk(rd, ev, em);
    endtask
    task automatic readback();
        apb(1'b0, BUS_SELECT_REGISTER_ADDR, 32'h0);
        chk(rd, sel_m, 32'hffffffff);
        apb(1'b0, UPPER_ADDR_PULL_INHIBIT_ADDR, 32'h0);
        chk(rd, up_m, 32'hffffffff);
        apb(1'b0, MID_ADDR_PULL_INHIBIT_ADDR, 32'h0);
        chk(rd, mid_m, 32'hffffffff);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ext_addr, ext_oe} = '0;
        {nand_en, cle, ale, gp_drv} = '0;
        gp_oe = 4'h0;
        ext_oe = 1'b1;
        arst_n = 1'b0;
        seed = 32'h3780;
        error_cnt = 0;
        checks = 0;
        do_reset();
        readback();
        pin_checks();
        apb(1'b0, 16'h7ffc, 32'h0);
        chk(err, 1'b1, 32'h1);
        apb(1'b1, PIN_LEVEL_STATUS_ADDR, 32'hffff);
        chk(err, 1'b0, 32'h1);
        repeat (40) begin
            // Random data kept off the bus pins so a landing write never sees it change
            wd = rnd();
            apb(1'b1, BUS_SELECT_REGISTER_ADDR, wd);
            sel_m = wd[3:0];
            wd = rnd();
            apb(1'b1, UPPER_ADDR_PULL_INHIBIT_ADDR, wd);
            up_m = wd[3:0];
            wd = rnd();
            apb(1'b1, MID_ADDR_PULL_INHIBIT_ADDR, wd);
            mid_m = wd[7:0];
            @(posedge clk);
            wd = rnd();
            {ext_addr, ext_oe, nand_en, cle, ale, gp_drv, gp_oe} <= wd[23:0];
            repeat (5) @(posedge clk);
            pin_checks();
            readback();
        end
        // Second reset in mid-run must restore general-purpose mode and pulls off
        do_reset();
        readback();
        pin_checks();
        test_done();
    end
endmodule
